// File: cst_timer_map.vh
// Purpose: Timer constants: addresses, bit positions, codes.
// Assumes: Included by the timer design files by bare name.
// Notes: Definitions only.
`ifndef CST_TIMER_MAP_VH
`define CST_TIMER_MAP_VH

// Special function register addresses.
`define CST_ADDR_CONTROL 8'hc8
`define CST_ADDR_MODE 8'hc9
`define CST_ADDR_MODE_ONE 8'h93
`define CST_ADDR_LOWER_RELOAD 8'hca
`define CST_ADDR_UPPER_RELOAD 8'hcb
`define CST_ADDR_LOWER_COUNT 8'hcc
`define CST_ADDR_UPPER_COUNT 8'hcd

// Reset value of every register.
`define CST_RESET_BYTE 8'h00

// Control register bit positions.
`define CST_C_OVF_FLAG 7
`define CST_C_EXT_FLAG 6
`define CST_C_LOW_OVF_FLAG 5
`define CST_C_LOW_IRQ_EN 4
`define CST_C_FALL_EN 3
`define CST_C_RUN 2
`define CST_C_COUNTER_SEL 1
`define CST_C_CAP_RELOAD 0

// Mode register bit positions.
`define CST_M_SPLIT 7
`define CST_M_BIT6 6
`define CST_M_RISE_EN 5
`define CST_M_X12 4
`define CST_M_LOW_RUN 3
`define CST_M_LOW_AUTOCLR 2
`define CST_M_CLK_OUT_EN 1
`define CST_M_MODE_SEL0 0

// Mode register one bit positions.
`define CST_M1_LOW_CLK_SEL1 7
`define CST_M1_OVF_IGNORE 6
`define CST_M1_BIT6_FUNC 5
`define CST_M1_BANK_SEL 4
`define CST_M1_MODE_SEL1 3
`define CST_M1_CAP_SRC_HI 2

// Operating mode codes {mode_sel1, capture_reload_select, mode_sel0}.
`define CST_MODE_AR_INT 3'b000
`define CST_MODE_AR_EXT 3'b001
`define CST_MODE_CAPTURE 3'b010
`define CST_MODE_CAP_ZERO 3'b011
`define CST_MODE_PWM 3'b100
`define CST_MODE_DUTY 3'b110

// Timing: system clock divided by twelve for the slow tick.
`define CST_PRESCALE 8'd12

// Counter limits.
`define CST_BYTE_MAX 8'hff
`define CST_WORD_MAX 16'hffff

`endif

// File: cst_sync_edge.v
// Purpose: Two-flop synchroniser with edge detection for a group of input lines.
// Assumes: One clock, asynchronous active-low reset.
// Notes: Edges compare the second flop with its previous sample.
`timescale 1ns/1ps
`default_nettype none
module cst_sync_edge #(
  parameter WIDTH = 2
) (
  input wire clk_i,
  input wire rstn_i,
  input wire [WIDTH-1:0] d_i,
  output wire [WIDTH-1:0] level_o,
  output wire [WIDTH-1:0] rise_o,
  output wire [WIDTH-1:0] fall_o
);
  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi = gi + 1) begin : g_line
      reg meta;
      reg stable;
      reg prev;
      // The first flop feeds only the second; edges come from the settled pair.
      always @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
          meta <= 1'b0;
          stable <= 1'b0;
          prev <= 1'b0;
        end else begin
          meta <= d_i[gi];
          stable <= meta;
          prev <= stable;
        end
      end
      // Edge pulses last exactly one clock.
      assign level_o[gi] = stable;
      assign rise_o[gi] = stable & ~prev;
      assign fall_o[gi] = ~stable & prev;
    end
  endgenerate
endmodule
`default_nettype wire

// File: cst_timer.v
// Purpose: 16-bit timer/counter with capture, duty capture, split 8-bit, PWM and clock-out.
// Assumes: Core reaches registers over a byte-wide special function register port.
// Notes: Software writes to a count byte win over hardware in the same cycle.
// Functional notes
// R1 - Auto-zero mode: strobe captures and clears counter.
// R2 - Duty mode: arm, start on first rising edge.
// R3 - Duty: second edge captures; flag if fall-enabled.
// R4 - Duty: third edge clears run bit, stops.
// R5 - Split: two 8-bit counters with own reloads.
// R6 - Split run gating; upper overflow clears low run.
// R7 - Split flags: upper and lower overflow flags.
// R8 - Flags only cleared by software.
// R9 - Split exports lower overflow event.
// R10 - Mode bit six shared by function select.
// R11 - Split variants apply modes to upper counter.
// R12 - PWM: upper period counter, lower compare buffer.
// R13 - PWM overflow sets flag, loads compare; gated.
// R14 - Whole clock-out toggles on overflow, reloads.
// R15 - Clock-out rollovers still set overflow flag.
// R16 - Split clock-out toggles on lower overflow.
// R17 - Software sets lower clock before split clock-out.
// R18 - Software start order for clock-out.
// R19 - External flag on enabled falling/rising edge.
// R20 - Power-down: external flag is level wake.
// R21 - Plain auto-reload mode: edge only sets flag.
// R22 - Three-bit clock source select, split code 011.
// R23 - Low overflow enable feeds shared interrupt.
// R24 - Lower counter clock from two select bits.
// R25 - Mode decode from three select bits.
// R26 - Synchronise and edge-detect external inputs.
`timescale 1ns/1ps
`default_nettype none
`include "cst_timer_map.vh"
module cst_timer #(
  parameter [7:0] PRESCALE = `CST_PRESCALE
) (
  input wire clk_i,
  input wire rstn_i,
  input wire [7:0] sfr_addr_i,
  input wire [7:0] sfr_wdata_i,
  input wire sfr_we_i,
  input wire sfr_re_i,
  output reg [7:0] sfr_rdata_o,
  input wire count_pin_i,
  input wire ext_trigger_input_i,
  input wire ext_int1_trigger_i,
  input wire serial1_rate_overflow_i,
  input wire timer0_overflow_i,
  input wire comparator1_event_i,
  input wire timer1_overflow_i,
  input wire power_down_i,
  input wire irq_enable_i,
  output wire [2:0] capture_src_sel_o,
  output wire timer_irq_o,
  output wire wake_o,
  output reg overflow_event_o,
  output reg low_overflow_event_o,
  output reg ext_event_strobe_o,
  output reg clock_out_pin_o
);
  localparam [1:0] D_ARM = 2'd0;
  localparam [1:0] D_FIRST = 2'd1;
  localparam [1:0] D_SECOND = 2'd2;

  // Control register fields.
  reg overflow_flag, external_flag, low_overflow_flag, low_overflow_irq_enable;
  reg fall_edge_enable, run_bit, counter_select, capture_reload_select;
  // Mode register fields; bit six has two backing bits.
  reg split_enable, low_clock_sel0, ext_input_invert, rise_edge_enable, clock_x12_select;
  reg low_run_bit, low_run_autoclear, clock_out_enable, mode_sel0;
  // Mode register one fields.
  reg low_clock_sel1, overflow_irq_ignore, bit6_function_select, clock_bank_select, mode_sel1;
  reg [2:0] cap_src;
  // Counter and reload bytes.
  reg [7:0] upper_count, lower_count, upper_reload, lower_reload;
  reg [7:0] pre_cnt;
  reg pre_tick;
  reg [1:0] duty_state;
  reg clk_toggle;

  // Picks one event line out of eight by a select code.
  function pick8;
    input [2:0] sel;
    input [7:0] lines;
    begin
      pick8 = lines[sel];
    end
  endfunction

  // Input synchroniser for the count pin and the external trigger.
  wire [1:0] in_lvl, in_rise, in_fall;
  cst_sync_edge #(.WIDTH(2)) u_sync (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .d_i({ext_trigger_input_i, count_pin_i}),
    .level_o(),
    .rise_o(in_rise),
    .fall_o(in_fall)
  ); // R26

  // Inversion swaps the edge kinds rather than re-registering the line.
  wire ext_rise = ext_input_invert ? in_fall[1] : in_rise[1]; // R10
  wire ext_fall = ext_input_invert ? in_rise[1] : in_fall[1]; // R10
  wire ext_edge = ext_rise | ext_fall;

  // Mode decode.
  wire [2:0] mode = {mode_sel1, capture_reload_select, mode_sel0}; // R25
  wire duty = ~split_enable & (mode == `CST_MODE_DUTY); // R25
  wire pwm = split_enable & (mode == `CST_MODE_PWM); // R12
  wire ar_ext = (mode == `CST_MODE_AR_EXT);
  wire cap_any = (mode == `CST_MODE_CAPTURE) | (mode == `CST_MODE_CAP_ZERO);
  wire cap_zero = (mode == `CST_MODE_CAP_ZERO);

  // Enabled edges form the external event strobe; duty mode runs its own edge sequence.
  wire ext_hit = ~duty & ((ext_fall & fall_edge_enable) | (ext_rise & rise_edge_enable)); // R19 R21

  // Lower counter runs from four sources.
  wire low_tick = pick8({1'b0, low_clock_sel1, low_clock_sel0},
                        {4'h0, ext_int1_trigger_i, serial1_rate_overflow_i, 1'b1, pre_tick}); // R24
  wire low_en = split_enable & low_run_bit & low_tick & ~pwm; // R6
  wire low_of = low_en & (lower_count == `CST_BYTE_MAX); // R5

  // Upper or whole counter source; code 011 becomes the lower overflow in split mode.
  wire code3_src = split_enable ? low_of : ext_int1_trigger_i; // R22
  wire up_tick = pick8({clock_bank_select, clock_x12_select, counter_select},
                       {timer1_overflow_i, comparator1_event_i, timer0_overflow_i, serial1_rate_overflow_i,
                        code3_src, 1'b1, in_fall[0], pre_tick}); // R22

  // Duty edge sequence: arm, then count from the first rising edge.
  wire duty_start = duty & run_bit & (duty_state == D_ARM) & ext_rise; // R2
  wire duty_cap = duty & run_bit & (duty_state == D_FIRST) & ext_edge; // R3
  wire duty_stop = duty & run_bit & (duty_state == D_SECOND) & ext_edge; // R4
  wire duty_counting = ~duty | (duty_state != D_ARM); // R2

  // Whole counter events.
  wire whole_en = ~split_enable & run_bit & up_tick & duty_counting;
  wire whole_of = whole_en & ({upper_count, lower_count} == `CST_WORD_MAX);
  wire whole_reload = ~split_enable & ((whole_of & ~capture_reload_select) | (ext_hit & ar_ext)); // R14
  wire whole_zero = ~split_enable & ext_hit & cap_zero; // R1
  wire whole_cap = (~split_enable & ext_hit & cap_any) | duty_cap; // R1 R3

  // Split upper counter events mirror the whole reload and capture modes on eight bits.
  wire up_en = split_enable & run_bit & up_tick; // R6
  wire up_of = up_en & (upper_count == `CST_BYTE_MAX); // R7
  wire up_reload = split_enable & ((up_of & ~capture_reload_select) | (ext_hit & ar_ext)); // R11
  wire up_zero = split_enable & ext_hit & cap_zero; // R11
  wire up_cap = split_enable & ext_hit & cap_any; // R11

  // Low run bit cleared by upper overflow or capture input when autoclear is set.
  wire low_run_clear = split_enable & low_run_autoclear & (up_of | (ext_hit & cap_any)); // R6

  // Flag set sources; these never clear anything on their own.
  wire set_ovf = whole_of | up_of; // R7 R13 R15
  wire set_ext = ext_hit | (duty_cap & fall_edge_enable); // R3 R19 R21
  wire set_low = low_of; // R7

  // Clock-out toggle source picks the lower counter in split mode.
  wire toggle_ev = split_enable ? low_of : whole_of; // R14 R16
  wire pwm_level = (upper_count >= lower_count); // R12

  // Register write strobes.
  wire wr_ctrl = sfr_we_i & (sfr_addr_i == `CST_ADDR_CONTROL);
  wire wr_mode = sfr_we_i & (sfr_addr_i == `CST_ADDR_MODE);
  wire wr_mode1 = sfr_we_i & (sfr_addr_i == `CST_ADDR_MODE_ONE);
  wire wr_uc = sfr_we_i & (sfr_addr_i == `CST_ADDR_UPPER_COUNT);
  wire wr_lc = sfr_we_i & (sfr_addr_i == `CST_ADDR_LOWER_COUNT);
  wire wr_ur = sfr_we_i & (sfr_addr_i == `CST_ADDR_UPPER_RELOAD);
  wire wr_lr = sfr_we_i & (sfr_addr_i == `CST_ADDR_LOWER_RELOAD);

  // Divide-by-twelve tick for the slow clock sources.
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pre_cnt <= 8'h00;
      pre_tick <= 1'b0;
    end else if (pre_cnt == PRESCALE - 8'h01) begin
      pre_cnt <= 8'h00;
      pre_tick <= 1'b1;
    end else begin
      pre_cnt <= pre_cnt + 8'h01;
      pre_tick <= 1'b0;
    end
  end

  // Configuration registers; a hardware set wins over a software clear in the same cycle.
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      {overflow_flag, external_flag, low_overflow_flag, low_overflow_irq_enable} <= 4'h0;
      {fall_edge_enable, run_bit, counter_select, capture_reload_select} <= 4'h0;
      {split_enable, low_clock_sel0, ext_input_invert, rise_edge_enable, clock_x12_select} <= 5'h00;
      {low_run_bit, low_run_autoclear, clock_out_enable, mode_sel0} <= 4'h0;
      {low_clock_sel1, overflow_irq_ignore, bit6_function_select, clock_bank_select, mode_sel1} <= 5'h00;
      cap_src <= 3'h0;
    end else begin
      overflow_flag <= (wr_ctrl ? sfr_wdata_i[`CST_C_OVF_FLAG] : overflow_flag) | set_ovf; // R8
      external_flag <= (wr_ctrl ? sfr_wdata_i[`CST_C_EXT_FLAG] : external_flag) | set_ext; // R8
      low_overflow_flag <= (wr_ctrl ? sfr_wdata_i[`CST_C_LOW_OVF_FLAG] : low_overflow_flag) | set_low; // R8
      if (wr_ctrl) begin
        low_overflow_irq_enable <= sfr_wdata_i[`CST_C_LOW_IRQ_EN];
        fall_edge_enable <= sfr_wdata_i[`CST_C_FALL_EN];
        run_bit <= sfr_wdata_i[`CST_C_RUN];
        counter_select <= sfr_wdata_i[`CST_C_COUNTER_SEL];
        capture_reload_select <= sfr_wdata_i[`CST_C_CAP_RELOAD];
      end else if (duty_stop) begin
        run_bit <= 1'b0; // R4
      end
      if (wr_mode) begin
        split_enable <= sfr_wdata_i[`CST_M_SPLIT];
        if (bit6_function_select) begin
          ext_input_invert <= sfr_wdata_i[`CST_M_BIT6]; // R10
        end else begin
          low_clock_sel0 <= sfr_wdata_i[`CST_M_BIT6]; // R10
        end
        rise_edge_enable <= sfr_wdata_i[`CST_M_RISE_EN];
        clock_x12_select <= sfr_wdata_i[`CST_M_X12];
        low_run_bit <= sfr_wdata_i[`CST_M_LOW_RUN];
        low_run_autoclear <= sfr_wdata_i[`CST_M_LOW_AUTOCLR];
        clock_out_enable <= sfr_wdata_i[`CST_M_CLK_OUT_EN];
        mode_sel0 <= sfr_wdata_i[`CST_M_MODE_SEL0];
      end else if (low_run_clear) begin
        low_run_bit <= 1'b0; // R6
      end
      if (wr_mode1) begin
        low_clock_sel1 <= sfr_wdata_i[`CST_M1_LOW_CLK_SEL1];
        overflow_irq_ignore <= sfr_wdata_i[`CST_M1_OVF_IGNORE];
        bit6_function_select <= sfr_wdata_i[`CST_M1_BIT6_FUNC];
        clock_bank_select <= sfr_wdata_i[`CST_M1_BANK_SEL];
        mode_sel1 <= sfr_wdata_i[`CST_M1_MODE_SEL1];
        cap_src <= sfr_wdata_i[`CST_M1_CAP_SRC_HI:0];
      end
    end
  end

  // Duty capture sequencer; leaving duty mode or stopping re-arms it.
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      duty_state <= D_ARM;
    end else if (!duty || !run_bit) begin
      duty_state <= D_ARM;
    end else begin
      case (duty_state)
        D_ARM: begin
          if (duty_start) begin
            duty_state <= D_FIRST; // R2
          end
        end
        D_FIRST: begin
          if (duty_cap) begin
            duty_state <= D_SECOND; // R3
          end
        end
        D_SECOND: begin
          if (duty_stop) begin
            duty_state <= D_ARM; // R4
          end
        end
        default: begin
          duty_state <= D_ARM;
        end
      endcase
    end
  end

  // Counters and reload bytes; later assignments take priority.
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      upper_count <= `CST_RESET_BYTE;
      lower_count <= `CST_RESET_BYTE;
      upper_reload <= `CST_RESET_BYTE;
      lower_reload <= `CST_RESET_BYTE;
    end else begin
      if (wr_ur) begin
        upper_reload <= sfr_wdata_i;
      end
      if (wr_lr) begin
        lower_reload <= sfr_wdata_i;
      end
      // Capture overrides a same-cycle software write so the event is kept.
      if (whole_cap) begin
        upper_reload <= upper_count; // R1 R3
        lower_reload <= lower_count; // R1 R3
      end else if (up_cap) begin
        upper_reload <= upper_count; // R11
      end
      if (whole_zero) begin
        {upper_count, lower_count} <= 16'h0000; // R1
      end else if (whole_reload) begin
        {upper_count, lower_count} <= {upper_reload, lower_reload}; // R14
      end else if (whole_en) begin
        {upper_count, lower_count} <= {upper_count, lower_count} + 16'h0001;
      end
      if (up_zero) begin
        upper_count <= 8'h00; // R11
      end else if (up_reload) begin
        upper_count <= upper_reload; // R5 R12
      end else if (up_en) begin
        upper_count <= upper_count + 8'h01; // R5
      end
      if (pwm && up_of) begin
        lower_count <= lower_reload; // R13
      end else if (low_of) begin
        lower_count <= lower_reload; // R5 R16
      end else if (low_en) begin
        lower_count <= lower_count + 8'h01; // R5
      end
      if (wr_uc) begin
        upper_count <= sfr_wdata_i;
      end
      if (wr_lc) begin
        lower_count <= sfr_wdata_i;
      end
    end
  end

  // Clock-out pin, exported events and registered read data.
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      clk_toggle <= 1'b0;
      clock_out_pin_o <= 1'b0;
      overflow_event_o <= 1'b0;
      low_overflow_event_o <= 1'b0;
      ext_event_strobe_o <= 1'b0;
      sfr_rdata_o <= 8'h00;
    end else begin
      if (!clock_out_enable || capture_reload_select) begin
        clk_toggle <= 1'b0;
      end else if (toggle_ev) begin
        clk_toggle <= ~clk_toggle; // R14 R16
      end
      clock_out_pin_o <= clock_out_enable & (pwm ? pwm_level : clk_toggle); // R13
      overflow_event_o <= split_enable ? low_of : whole_of; // R9
      low_overflow_event_o <= low_of;
      ext_event_strobe_o <= ext_hit;
      if (!sfr_re_i) begin
        sfr_rdata_o <= 8'h00;
      end else if (sfr_addr_i == `CST_ADDR_CONTROL) begin
        sfr_rdata_o <= {overflow_flag, external_flag, low_overflow_flag, low_overflow_irq_enable,
                        fall_edge_enable, run_bit, counter_select, capture_reload_select};
      end else if (sfr_addr_i == `CST_ADDR_MODE) begin
        sfr_rdata_o <= {split_enable, (bit6_function_select ? ext_input_invert : low_clock_sel0),
                        rise_edge_enable, clock_x12_select, low_run_bit, low_run_autoclear,
                        clock_out_enable, mode_sel0}; // R10
      end else if (sfr_addr_i == `CST_ADDR_MODE_ONE) begin
        sfr_rdata_o <= {low_clock_sel1, overflow_irq_ignore, bit6_function_select, clock_bank_select,
                        mode_sel1, cap_src};
      end else if (sfr_addr_i == `CST_ADDR_UPPER_COUNT) begin
        sfr_rdata_o <= upper_count;
      end else if (sfr_addr_i == `CST_ADDR_LOWER_COUNT) begin
        sfr_rdata_o <= lower_count;
      end else if (sfr_addr_i == `CST_ADDR_UPPER_RELOAD) begin
        sfr_rdata_o <= upper_reload;
      end else if (sfr_addr_i == `CST_ADDR_LOWER_RELOAD) begin
        sfr_rdata_o <= lower_reload;
      end else begin
        sfr_rdata_o <= 8'h00;
      end
    end
  end

  // Shared timer request; the ignore bit masks only the overflow flag.
  assign timer_irq_o = irq_enable_i & ((overflow_flag & ~overflow_irq_ignore) | external_flag |
                                       (low_overflow_flag & low_overflow_irq_enable)); // R15 R23
  // In power-down the external flag acts as a held level, so it wakes the core until cleared.
  assign wake_o = power_down_i & irq_enable_i & external_flag; // R20
  assign capture_src_sel_o = cap_src;
endmodule
`default_nettype wire

// File: cst_core_model.sv
// Purpose: Core model on the register bus.
// Assumes: One access at a time.
// Notes: Released bus shows the inverse.
`timescale 1ns/1ps
`default_nettype none
`include "cst_timer_map.vh"
module cst_core_model (
  input wire logic clk_i,
  input wire logic [7:0] rdata_i,
  output logic [7:0] addr_o,
  output logic [7:0] wdata_o,
  output logic we_o,
  output logic re_o
);
  // Idle bus at time zero.
  initial begin
    {addr_o, wdata_o, we_o, re_o} = 18'h0;
  end
  // Write strobe stands for one edge only.
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_o <= a;
    wdata_o <= d;
    we_o <= 1'b1;
    @(posedge clk_i);
    we_o <= 1'b0;
    addr_o <= ~a;
    wdata_o <= ~d;
  endtask
  // Read data is registered: taken a cycle after the strobe.
  task rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_i);
    addr_o <= a;
    re_o <= 1'b1;
    @(posedge clk_i);
    re_o <= 1'b0;
    addr_o <= ~a;
    @(negedge clk_i);
    d = rdata_i;
  endtask
  // Source, reloads and count, enable, then run.
  task clk_out(input logic [7:0] md, input logic [7:0] ctl, input logic [15:0] v);
    wr(`CST_ADDR_MODE, md);
    wr(`CST_ADDR_LOWER_RELOAD, v[7:0]);
    wr(`CST_ADDR_UPPER_RELOAD, v[15:8]);
    wr(`CST_ADDR_LOWER_COUNT, v[7:0]);
    wr(`CST_ADDR_UPPER_COUNT, v[15:8]);
    wr(`CST_ADDR_MODE, md | 8'h02);
    wr(`CST_ADDR_CONTROL, ctl);
  endtask
endmodule
`default_nettype wire

// File: cst_timer_assertions.sv
// Purpose: Port checks on the timer.
// Assumes: Sees the top-level ports only.
// Notes: Mode bits shadowed from writes.
`timescale 1ns/1ps
`default_nettype none
`include "cst_timer_map.vh"
module cst_timer_assertions (
  input wire clk_i,
  input wire rstn_i,
  input wire [7:0] sfr_addr_i,
  input wire [7:0] sfr_wdata_i,
  input wire sfr_we_i,
  input wire sfr_re_i,
  input wire [7:0] sfr_rdata_o,
  input wire power_down_i,
  input wire irq_enable_i,
  input wire [2:0] capture_src_sel_o,
  input wire wake_o,
  input wire overflow_event_o,
  input wire low_overflow_event_o,
  input wire ext_event_strobe_o,
  input wire clock_out_pin_o
);
  reg oe_q;
  reg rise_q;
  reg split_q;
  reg fall_q;
  wire mapped;
  // Decode of the seven timer addresses.
  assign mapped = sfr_addr_i inside {`CST_ADDR_CONTROL, `CST_ADDR_MODE, `CST_ADDR_MODE_ONE,
    `CST_ADDR_LOWER_RELOAD, `CST_ADDR_UPPER_RELOAD, `CST_ADDR_LOWER_COUNT, `CST_ADDR_UPPER_COUNT};
  // Hardware never changes these bits.
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      {split_q, rise_q, oe_q, fall_q} <= 4'h0;
    end else if (sfr_we_i && sfr_addr_i == `CST_ADDR_MODE) begin
      {split_q, rise_q, oe_q} <= {sfr_wdata_i[7], sfr_wdata_i[5], sfr_wdata_i[1]};
    end else if (sfr_we_i && sfr_addr_i == `CST_ADDR_CONTROL) begin
      fall_q <= sfr_wdata_i[3];
    end
  end
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rstn_i);
  sequence s_wr_one;
    sfr_we_i && sfr_addr_i == `CST_ADDR_MODE_ONE;
  endsequence
  sequence s_rd_one;
    sfr_re_i && sfr_addr_i == `CST_ADDR_MODE_ONE;
  endsequence
  a_mode_one_readback: assert property (s_wr_one ##1 !sfr_we_i ##1 s_rd_one |=>
    sfr_rdata_o == $past(sfr_wdata_i, 3)) else $error("mode one readback wrong");
  a_unmapped_zero: assert property (sfr_re_i && !mapped |=> sfr_rdata_o == 8'h00)
    else $error("unmapped read not zero");
  a_rdata_idle: assert property (!sfr_re_i |=> sfr_rdata_o == 8'h00) else $error("read data not idle");
  a_capsel_follows: assert property (s_wr_one |=> capture_src_sel_o == $past(sfr_wdata_i[2:0]))
    else $error("capture select wrong");
  a_clkout_gated: assert property (!oe_q ##1 !oe_q |-> !clock_out_pin_o)
    else $error("clock out without enable");
  a_strobe_enabled: assert property (ext_event_strobe_o |-> $past(fall_q || rise_q))
    else $error("strobe without edge enable");
  a_wake_gated: assert property (wake_o |-> power_down_i && irq_enable_i)
    else $error("wake outside power down");
  a_split_event: assert property (split_q && $past(split_q, 2) |->
    overflow_event_o == low_overflow_event_o) else $error("split overflow event wrong");
endmodule
bind cst_timer cst_timer_assertions u_chk (.clk_i(clk_i), .rstn_i(rstn_i), .sfr_addr_i(sfr_addr_i),
  .sfr_wdata_i(sfr_wdata_i), .sfr_we_i(sfr_we_i), .sfr_re_i(sfr_re_i), .sfr_rdata_o(sfr_rdata_o),
  .power_down_i(power_down_i), .irq_enable_i(irq_enable_i), .capture_src_sel_o(capture_src_sel_o),
  .wake_o(wake_o), .overflow_event_o(overflow_event_o), .low_overflow_event_o(low_overflow_event_o),
  .ext_event_strobe_o(ext_event_strobe_o), .clock_out_pin_o(clock_out_pin_o));
`default_nettype wire

// File: tb_capture_split_timer.sv
// Purpose: Bench for the timer.
// Assumes: System clock source, exact counts.
// Notes: Edge results allow for sync delay.
`timescale 1ns/1ps
`default_nettype none
module tb_capture_split_timer;
  logic clk_i, rstn_i, ext_trig, int1, pd, irqen;
  wire [7:0] addr, wdata, rdata;
  wire [2:0] capsel;
  wire we, re, irq, wake, ovf, lovf, exts, cko;
  int num_errors, compares, n_tog, n_ovf, n_low, n_ext;
  logic [7:0] r, rd_d;
  logic [7:0] regs [8] = '{8'hc8, 8'hc9, 8'h93, 8'hca, 8'hcb, 8'hcc, 8'hcd, 8'hc0};
  cst_core_model core (.clk_i(clk_i), .rdata_i(rdata), .addr_o(addr), .wdata_o(wdata), .we_o(we), .re_o(re));
  cst_timer #(.PRESCALE(8'd3)) dut (.clk_i(clk_i), .rstn_i(rstn_i), .sfr_addr_i(addr), .sfr_wdata_i(wdata),
    .sfr_we_i(we), .sfr_re_i(re), .sfr_rdata_o(rdata), .count_pin_i(int1), .ext_trigger_input_i(ext_trig),
    .ext_int1_trigger_i(int1), .serial1_rate_overflow_i(1'b0), .timer0_overflow_i(1'b0),
    .comparator1_event_i(1'b0), .timer1_overflow_i(1'b0), .power_down_i(pd), .irq_enable_i(irqen),
    .capture_src_sel_o(capsel), .timer_irq_o(irq), .wake_o(wake), .overflow_event_o(ovf),
    .low_overflow_event_o(lovf), .ext_event_strobe_o(exts), .clock_out_pin_o(cko));
  // Free-running system clock.
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  // Random pulses on unselected lines expose a wrong source pick.
  always @(posedge clk_i) int1 <= 1'($urandom);
  // Tallies for rate checks.
  always @(cko) n_tog++;
  always @(posedge ovf) n_ovf++;
  always @(posedge lovf) n_low++;
  always @(posedge exts) n_ext++;
  task clr();
    {n_tog, n_ovf, n_low, n_ext} = 128'h0;
  endtask
  task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    compares++;
    if (g !== e) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task rng(input string nm, input int lo, input int hi, input logic [15:0] g);
    compares++;
    if ($isunknown(g) || g < lo || g > hi) begin
      num_errors++;
      $display("[ERR] %s expected %0d..%0d seen %h", nm, lo, hi, g);
    end
  endtask
  task rdm(input string nm, input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
    core.rd(a, rd_d);
    chk(nm, e, rd_d & m);
  endtask
  task conclude();
    $display("compares %0d num_errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Watchdog, more than ten times the expected run.
  initial begin
    repeat (5000) @(posedge clk_i);
    num_errors++;
    conclude();
  end
  // Main sequence.
  initial begin
    void'($urandom(32'h4fad));
    {rstn_i, ext_trig, int1, pd, irqen} = 5'b01000;
    repeat (3) @(posedge clk_i);
    rstn_i <= 1'b1;
    foreach (regs[i]) rdm("reset_value", regs[i], 8'hff, 8'h00);
    repeat (4) begin
      r = 8'($urandom);
      core.wr(regs[2], r);
      rdm("mode_one", regs[2], 8'hff, r);
      chk("capsel", r[2:0], capsel);
    end
    core.wr(regs[2], 8'h00);
    // Whole clock-out, overflow every second cycle.
    core.clk_out(8'h10, 8'h04, 16'hfffe);
    clr();
    repeat (40) @(posedge clk_i);
    rng("toggles", 18, 22, n_tog);
    rng("overflows", 18, 22, n_ovf);
    rdm("ovf_flag", regs[0], 8'h80, 8'h80);
    // Capture with auto-zero on a falling edge.
    core.wr(regs[1], 8'h11);
    core.wr(regs[5], 8'h00);
    core.wr(regs[6], 8'h00);
    clr();
    core.wr(regs[0], 8'h0d);
    repeat (40) @(posedge clk_i);
    ext_trig <= 1'b0;
    repeat (10) @(posedge clk_i);
    rdm("ext_flag", regs[0], 8'h40, 8'h40);
    core.wr(regs[0], 8'h49);
    rdm("upper_zeroed", regs[6], 8'hff, 8'h00);
    core.rd(regs[5], rd_d);
    rng("lower_zeroed", 8, 20, rd_d);
    core.rd(regs[3], rd_d);
    rng("captured", 38, 50, rd_d);
    chk("strobes", 1, n_ext);
    // Duty capture: arm, rise starts, fall captures, rise stops.
    core.wr(regs[0], 8'h00);
    for (int i = 3; i < 7; i++) core.wr(regs[i], 8'h00);
    core.wr(regs[2], 8'h08);
    core.wr(regs[1], 8'h30);
    core.wr(regs[0], 8'h0d);
    repeat (20) @(posedge clk_i);
    rdm("armed", regs[5], 8'hff, 8'h00);
    ext_trig <= 1'b1;
    repeat (30) @(posedge clk_i);
    rdm("first_edge", regs[0], 8'h40, 8'h00);
    ext_trig <= 1'b0;
    repeat (20) @(posedge clk_i);
    ext_trig <= 1'b1;
    repeat (10) @(posedge clk_i);
    rdm("third_edge", regs[0], 8'h44, 8'h40);
    core.rd(regs[3], rd_d);
    rng("pulse", 28, 40, rd_d);
    core.rd(regs[5], rd_d);
    rng("cycle", 45, 62, rd_d);
    @(posedge clk_i);
    pd <= 1'b1;
    irqen <= 1'b1;
    @(negedge clk_i);
    chk("wake", 1, wake);
    chk("irq", 1, irq);
    @(posedge clk_i);
    pd <= 1'b0;
    // Split: lower counter alone, reload fc, with split clock-out.
    core.wr(regs[0], 8'h00);
    core.wr(regs[2], 8'h00);
    core.clk_out(8'hc0, 8'h00, 16'h00fc);
    core.wr(regs[1], 8'hca);
    clr();
    repeat (40) @(posedge clk_i);
    rng("low_ovf", 9, 11, n_low);
    rng("split_ovf", 9, 11, n_ovf);
    rng("split_toggles", 9, 11, n_tog);
    rdm("split_flags", regs[0], 8'ha0, 8'h20);
    chk("irq_masked", 0, irq);
    rdm("upper_idle", regs[6], 8'hff, 8'h00);
    core.wr(regs[1], 8'hc2);
    repeat (10) @(posedge clk_i);
    rdm("flag_kept", regs[0], 8'h20, 8'h20);
    core.wr(regs[4], 8'hff);
    core.wr(regs[6], 8'hff);
    core.wr(regs[1], 8'hde);
    core.wr(regs[0], 8'h04);
    repeat (10) @(posedge clk_i);
    rdm("autoclear", regs[1], 8'hff, 8'hd6);
    rdm("upper_flag", regs[0], 8'h84, 8'h84);
    conclude();
  end
endmodule
`default_nettype wire
